// ### rtl/epc_ctrl.sv
// Programming controller that sequences mode pins and pulses for a UV-erasable memory.
`timescale 1ns/1ps
// What this block does
// - Whole byte presented in parallel; chip enable pulsed after setup.
// - Short algorithm: 100 us pulses, verify each, fail after ten.
// - Program mode: output enable high, chip enable low, elevated supplies.
// - After programming, byte is verified again at 5 V supplies.
// - Any address may be programmed in any order.
// - Parallel-wired devices are driven as one target.
// - Millisecond algorithm: 1 ms prime pulses, verify after each.
// - Repeat prime pulses while verify fails, stop at 25.
// - Closing pulse lasts three milliseconds per prime pulse used.
// - Millisecond algorithm holds 6 V core and 12.5 V programming supply.
// - Chip enable high inhibits programming even with supply applied.
// - Signature mode raises the identification pin to 12 V.
// - Lowest address selects maker or part byte; other address bits low.
// - Read drives both enables low; raising either floats the outputs.
module epc_ctrl import epc_pkg::*; #(
  parameter int SHORT_PULSE_CYC = EPC_SHORT_PULSE_CYC,
  parameter int PRIME_PULSE_CYC = EPC_PRIME_PULSE_CYC,
  parameter int SETUP_CYC = EPC_SETUP_CYC,
  parameter int SHORT_MAX = EPC_SHORT_MAX_PULSES,
  parameter int FAST_MAX = EPC_FAST_MAX_PULSES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire epc_req_t req_i,
  output logic rsp_valid_o,
  output epc_rsp_t rsp_o,
  input wire logic supply_good_i,
  input wire logic [EPC_DATA_W-1:0] data_pins_i,
  output epc_pins_t pins_o
);
  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_SUPPLY = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_PULSE = 4'b0011,
    ST_GAP = 4'b0100,
    ST_VERIFY = 4'b0101,
    ST_FINAL = 4'b0110,
    ST_LOWSUP = 4'b0111,
    ST_FINAL_VER = 4'b1000,
    ST_READ = 4'b1001,
    ST_DONE = 4'b1010,
    ST_FINAL_SETUP = 4'b1011
  } epc_state_t;

  typedef struct packed {
    epc_state_t state;
    epc_req_t req;
    epc_pins_t pins;
    logic [EPC_CNT_W-1:0] cnt;
    logic [EPC_PCNT_W-1:0] pulses;
    epc_rsp_t rsp;
    logic rsp_valid;
  } epc_ctrl_st_t;

  epc_ctrl_st_t st;
  epc_ctrl_st_t next_st;
  logic [EPC_DATA_W-1:0] rd_data;

  // Read-back passes four flops because the memory is asynchronous to this clock.
  epc_sync #(.WIDTH(EPC_DATA_W)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(data_pins_i),
    .sync_o(rd_data)
  );

  // Sample delay covers access time plus the three-stage synchroniser.
  localparam logic [EPC_CNT_W-1:0] SAMPLE_CYC = EPC_CNT_W'(SETUP_CYC + 4);
  logic is_fast;
  assign is_fast = (st.req.cmd == EPC_CMD_PROG_FAST);

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    next_st.rsp_valid = 1'b0;
    case (st.state)
      ST_IDLE: begin
        next_st.pins.chip_en_n = 1'b1;
        next_st.pins.out_en_n = 1'b1;
        next_st.pins.data_oe = 1'b0;
        if (req_valid_i) begin
          next_st.req = req_i;
          next_st.pulses = '0;
          next_st.cnt = '0;
          next_st.rsp = '0;
          next_st.pins.addr = req_i.addr;
          next_st.pins.data = req_i.data;
          case (req_i.cmd)
            EPC_CMD_PROG_SHORT: begin
              if (req_i.data == EPC_BLANK) begin
                next_st.state = ST_LOWSUP;
              end else begin
                next_st.pins.supply = EPC_SUP_SHORT;
                next_st.state = ST_SUPPLY;
              end
            end
            EPC_CMD_PROG_FAST: begin
              if (req_i.data == EPC_BLANK) begin
                next_st.state = ST_LOWSUP;
              end else begin
                next_st.pins.supply = EPC_SUP_FAST;
                next_st.state = ST_SUPPLY;
              end
            end
            EPC_CMD_SIGNATURE: begin
              next_st.pins.id_high_voltage_pin = 1'b1;
              next_st.pins.addr = '0;
              next_st.pins.addr[0] = req_i.addr[0];
              next_st.state = ST_READ;
            end
            default: begin
              next_st.state = ST_READ;
            end
          endcase
        end
      end
      ST_SUPPLY: begin
        if (supply_good_i) begin
          next_st.pins.data_oe = 1'b1;
          next_st.cnt = '0;
          next_st.state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt >= EPC_CNT_W'(SETUP_CYC - 1)) begin
          next_st.cnt = '0;
          next_st.pins.out_en_n = 1'b1;
          next_st.pins.chip_en_n = 1'b0;
          next_st.pulses = st.pulses + 1'b1;
          next_st.state = ST_PULSE;
        end
      end
      ST_PULSE: begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt >= EPC_CNT_W'((is_fast ? PRIME_PULSE_CYC : SHORT_PULSE_CYC) - 1)) begin
          next_st.pins.chip_en_n = 1'b1;
          next_st.cnt = '0;
          next_st.state = ST_GAP;
        end
      end
      ST_GAP: begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt >= EPC_CNT_W'(SETUP_CYC - 1)) begin
          // verify with output enable low, chip enable high
          next_st.pins.data_oe = 1'b0;
          next_st.pins.out_en_n = 1'b0;
          next_st.cnt = '0;
          next_st.state = ST_VERIFY;
        end
      end
      ST_VERIFY: begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt >= SAMPLE_CYC) begin
          next_st.cnt = '0;
          next_st.pins.out_en_n = 1'b1;
          next_st.pins.data_oe = 1'b1;
          if (rd_data == st.req.data) begin
            // good data leads to closing pulse in fast mode, straight to 5 V in short mode
            next_st.state = is_fast ? ST_FINAL_SETUP : ST_LOWSUP;
          // a cleared bit cannot come back
          end else if (((~rd_data) & st.req.data) != '0) begin
            next_st.rsp.fail = 1'b1;
            next_st.state = ST_LOWSUP;
          end else if (st.pulses >= EPC_PCNT_W'(is_fast ? FAST_MAX : SHORT_MAX)) begin
            next_st.rsp.fail = 1'b1;
            next_st.state = ST_LOWSUP;
          end else begin
            next_st.state = ST_SETUP;
          end
        end
      end
      ST_FINAL_SETUP: begin
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt >= EPC_CNT_W'(SETUP_CYC - 1)) begin
          next_st.cnt = '0;
          next_st.pins.chip_en_n = 1'b0;
          next_st.state = ST_FINAL;
        end
      end
      ST_FINAL: begin
        next_st.cnt = st.cnt + 1'b1;
        // closing pulse is three prime widths per pulse
        if (st.cnt >= EPC_CNT_W'(EPC_FINAL_FACTOR * PRIME_PULSE_CYC * int'(st.pulses) - 1)) begin
          next_st.pins.chip_en_n = 1'b1;
          next_st.cnt = '0;
          next_st.state = ST_LOWSUP;
        end
      end
      ST_LOWSUP: begin
        // return to 5 V for the closing verify
        next_st.pins.supply = EPC_SUP_READ;
        next_st.pins.chip_en_n = 1'b1;
        next_st.pins.data_oe = 1'b0;
        next_st.cnt = '0;
        if (supply_good_i && st.pins.supply == EPC_SUP_READ) begin
          next_st.state = ST_FINAL_VER;
        end
      end
      ST_FINAL_VER: begin
        next_st.pins.chip_en_n = 1'b0;
        next_st.pins.out_en_n = 1'b0;
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt >= SAMPLE_CYC) begin
          if (rd_data != st.req.data) begin
            next_st.rsp.fail = 1'b1;
          end
          next_st.rsp.data = rd_data;
          next_st.state = ST_DONE;
        end
      end
      ST_READ: begin
        next_st.pins.chip_en_n = 1'b0;
        next_st.pins.out_en_n = 1'b0;
        next_st.cnt = st.cnt + 1'b1;
        if (st.cnt >= SAMPLE_CYC) begin
          next_st.rsp.data = rd_data;
          if (st.req.cmd == EPC_CMD_SIGNATURE) begin
            next_st.rsp.fail = ~epc_odd_parity(rd_data);
          end
          next_st.state = ST_DONE;
        end
      end
      ST_DONE: begin
        // chip enable high parks and inhibits
        next_st.pins.chip_en_n = 1'b1;
        next_st.pins.out_en_n = 1'b1;
        next_st.pins.id_high_voltage_pin = 1'b0;
        next_st.rsp.pulses = st.pulses;
        next_st.rsp_valid = 1'b1;
        next_st.state = ST_IDLE;
      end
      default: begin
        next_st.state = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
      st.pins.chip_en_n <= 1'b1;
      st.pins.out_en_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // one pin set drives all parallel devices
  assign pins_o = st.pins;
  assign req_ready_o = (st.state == ST_IDLE);
  assign rsp_valid_o = st.rsp_valid;
  assign rsp_o = st.rsp;
endmodule

// ### rtl/epc_pkg.sv
// Package of constants, modes and carrier types for the programming controller.
package epc_pkg;
  localparam int EPC_ADDR_W = 15;
  localparam int EPC_DATA_W = 8;
  localparam int EPC_CLK_HZ = 10000000;
  localparam int EPC_SHORT_PULSE_US = 100;
  localparam int EPC_PRIME_PULSE_MS = 1;
  localparam int EPC_SETUP_US = 2;
  localparam int EPC_SHORT_MAX_PULSES = 10;
  localparam int EPC_FAST_MAX_PULSES = 25;
  localparam int EPC_FINAL_FACTOR = 3;
  localparam int EPC_SHORT_PULSE_CYC = (EPC_SHORT_PULSE_US * (EPC_CLK_HZ / 1000000) < 1) ? 1 :
                                       EPC_SHORT_PULSE_US * (EPC_CLK_HZ / 1000000);
  localparam int EPC_PRIME_PULSE_CYC = (EPC_PRIME_PULSE_MS * (EPC_CLK_HZ / 1000) < 1) ? 1 :
                                       EPC_PRIME_PULSE_MS * (EPC_CLK_HZ / 1000);
  localparam int EPC_SETUP_CYC = (EPC_SETUP_US * (EPC_CLK_HZ / 1000000) < 1) ? 1 :
                                 EPC_SETUP_US * (EPC_CLK_HZ / 1000000);
  localparam logic [7:0] EPC_BLANK = 8'hFF;
  localparam logic EPC_ID_MAKER = 1'b0;
  localparam logic EPC_ID_PART = 1'b1;
  localparam int EPC_CNT_W = 32;
  localparam int EPC_PCNT_W = 5;

  // Supply level requests for the external regulators.
  typedef enum logic [1:0] {
    EPC_SUP_READ = 2'b00,
    EPC_SUP_SHORT = 2'b01,
    EPC_SUP_FAST = 2'b10
  } epc_sup_t;

  typedef enum logic [1:0] {
    EPC_CMD_READ = 2'b00,
    EPC_CMD_PROG_SHORT = 2'b01,
    EPC_CMD_PROG_FAST = 2'b10,
    EPC_CMD_SIGNATURE = 2'b11
  } epc_cmd_t;

  typedef struct packed {
    epc_cmd_t cmd;
    logic [EPC_ADDR_W-1:0] addr;
    logic [EPC_DATA_W-1:0] data;
  } epc_req_t;

  typedef struct packed {
    logic [EPC_DATA_W-1:0] data;
    logic fail;
    logic [EPC_PCNT_W-1:0] pulses;
  } epc_rsp_t;

  typedef struct packed {
    logic chip_en_n;
    logic out_en_n;
    logic [EPC_ADDR_W-1:0] addr;
    logic [EPC_DATA_W-1:0] data;
    logic data_oe;
    logic id_high_voltage_pin;
    epc_sup_t supply;
  } epc_pins_t;

  // True when the read-back byte carries odd parity.
  function automatic logic epc_odd_parity(input logic [EPC_DATA_W-1:0] b);
    return ^b;
  endfunction
endpackage

// ### rtl/epc_sync.sv
// Three-stage input synchroniser for the data pins read back from the memory.
`timescale 1ns/1ps
module epc_sync import epc_pkg::*; #(
  parameter int WIDTH = EPC_DATA_W
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } epc_sync_st_t;
  epc_sync_st_t st;
  epc_sync_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = async_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // A change counts only once stages two and three agree.
    if (st.s2 == st.s3) begin
      next_st.q = st.s3;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.q;
endmodule

// ### tb/epc_ctrl_asserts.sv
// Assertions on the pin sequencing of the programming controller.
`timescale 1ns/1ps
module epc_ctrl_asserts import epc_pkg::*; #(
  parameter int SHORT_PULSE_CYC = EPC_SHORT_PULSE_CYC,
  parameter int PRIME_PULSE_CYC = EPC_PRIME_PULSE_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic rsp_valid_o,
  input wire epc_pins_t pins_o
);
  epc_pins_t p;
  logic [31:0] low;
  assign p = pins_o;
  // Length of the current chip enable low stretch, read at the edge where it ends.
  always_ff @(posedge ref_clk_i) begin
    low <= (!rst_n_i || p.chip_en_n) ? 32'h0 : low + 32'h1;
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////
  a_prog_mode: assert property (!p.chip_en_n && p.out_en_n |-> p.data_oe && p.supply != EPC_SUP_READ)
    else $error("program mode without drive or supply");
  a_no_clash: assert property (!p.out_en_n |-> !p.data_oe)
    else $error("data driven while memory outputs");
  a_verify_order: assert property ($fell(p.out_en_n) && p.supply != EPC_SUP_READ |->
    p.chip_en_n && $past(p.chip_en_n)) else $error("verify overlaps pulse");
  a_short_len: assert property ($rose(p.chip_en_n) && $past(p.supply) == EPC_SUP_SHORT |->
    low == SHORT_PULSE_CYC) else $error("short pulse length");
  a_prime_len: assert property ($rose(p.chip_en_n) && $past(p.supply) == EPC_SUP_FAST |->
    low == PRIME_PULSE_CYC || low % (EPC_FINAL_FACTOR * PRIME_PULSE_CYC) == 0) else $error("prime pulse length");
  a_setup_held: assert property ($fell(p.chip_en_n) && p.out_en_n |->
    $past(p.data_oe) && $stable(p.addr) && $stable(p.data)) else $error("pulse before setup");
  a_id_addr: assert property (p.id_high_voltage_pin && !p.out_en_n |-> p.addr[EPC_ADDR_W-1:1] == '0)
    else $error("upper address set in signature");
  a_final_5v: assert property (rsp_valid_o |-> p.supply == EPC_SUP_READ && p.chip_en_n && p.out_en_n)
    else $error("answer before read supply");
endmodule

bind epc_ctrl epc_ctrl_asserts #(.SHORT_PULSE_CYC(SHORT_PULSE_CYC), .PRIME_PULSE_CYC(PRIME_PULSE_CYC)) u_chk (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .rsp_valid_o(rsp_valid_o), .pins_o(pins_o));

// ### tb/epc_mem_model.sv
// Behavioural model of the memory device on the controller pins.
`timescale 1ns/1ps
module epc_mem_model import epc_pkg::*; #(
  // Arbitrary odd-parity identification bytes.
  parameter logic [7:0] MAKER_CODE = 8'h8C,
  parameter logic [7:0] PART_CODE = 8'h15
) (
  input wire logic ref_clk_i,
  input wire epc_pins_t pins_i,
  input wire logic [4:0] need_i,
  output logic [7:0] data_o,
  output logic supply_good_o
);
  logic [7:0] mem [0:32767];
  logic [7:0] last = 8'h00;
  logic [14:0] pa = 15'h0000;
  epc_pins_t prev;
  int hits = 0;
  int age = 0;
  logic drive;
  initial for (int i = 0; i < 32768; i++) mem[i] = 8'hFF;
  ////////////////////////
  // Sampled on the falling edge so the registered pins have settled.
  // Pulse end programs.
  always @(negedge ref_clk_i) begin
    if (prev.chip_en_n === 1'b0 && pins_i.chip_en_n && prev.out_en_n && prev.data_oe &&
        prev.supply != EPC_SUP_READ) begin
      hits = (prev.addr == pa) ? hits + 1 : 1;
      pa = prev.addr;
      if (hits >= need_i) mem[pa] = mem[pa] & prev.data;
    end
    age = (pins_i.supply == prev.supply) ? age + 1 : 0;
    if (drive) last = data_o;
    prev = pins_i;
  end
  assign supply_good_o = age > 3;
  // A released bus shows the inverse of its last value, never a lucky match.
  // Output drive.
  always_comb begin
    drive = !pins_i.out_en_n && (!pins_i.chip_en_n || pins_i.supply != EPC_SUP_READ);
    if (!drive) data_o = ~last;
    else if (pins_i.id_high_voltage_pin) data_o = pins_i.addr[0] ? PART_CODE : MAKER_CODE;
    else data_o = mem[pins_i.addr];
  end
endmodule

// ### tb/tb.sv
// Self-checking bench for the programming controller.
`timescale 1ns/1ps
module tb;
  import epc_pkg::*;
  localparam int PRIME_CYC = 20;
  localparam logic [7:0] MAKER_CODE = 8'h8C;
  localparam logic [7:0] PART_CODE = 8'h15;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  logic req_ready_o, rsp_valid_o, supply_good_i;
  logic [7:0] data_pins_i;
  logic [4:0] need = 5'h01;
  logic [15:0] low_run = 16'h0000;
  logic [15:0] max_low = 16'h0000;
  epc_req_t req_i = '0;
  epc_rsp_t rsp_o;
  epc_rsp_t r;
  epc_pins_t pins_o;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #50 ref_clk_i = ~ref_clk_i;
  epc_ctrl #(.SHORT_PULSE_CYC(10), .PRIME_PULSE_CYC(PRIME_CYC), .SETUP_CYC(2)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_i(req_i), .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .supply_good_i(supply_good_i),
    .data_pins_i(data_pins_i), .pins_o(pins_o));
  epc_mem_model #(.MAKER_CODE(MAKER_CODE), .PART_CODE(PART_CODE)) u_mem (.ref_clk_i(ref_clk_i),
    .pins_i(pins_o), .need_i(need), .data_o(data_pins_i), .supply_good_o(supply_good_i));
  ////////////////////////
  // Longest pulse and the hang limit, both on settled pins.
  always @(negedge ref_clk_i) begin
    cycles++;
    low_run = pins_o.chip_en_n ? 16'h0000 : low_run + 16'h0001;
    if (low_run > max_low) max_low = low_run;
    if (cycles == 20000) begin
      fail_count++;
      $display("MISMATCH %0t run did not finish", $time);
      close_out();
    end
  end
  task automatic close_out();
    $display("fail_count=%0d samples_checked=%0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk_rsp(input epc_rsp_t got, input epc_rsp_t exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t response %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input epc_cmd_t cmd, input logic [14:0] addr, input logic [7:0] data);
    @(negedge ref_clk_i);
    req_i = '{cmd, addr, data};
    req_valid_i = 1'b1;
    while (req_ready_o !== 1'b1) @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
    while (rsp_valid_o !== 1'b1) @(negedge ref_clk_i);
    r = rsp_o;
  endtask
  ////////////////////////
  task automatic t_short();
    run(EPC_CMD_READ, 15'h7FFF, 8'h00);
    chk_val({8'h00, r.data}, 16'h00FF);
    run(EPC_CMD_PROG_SHORT, 15'h0003, 8'hFF);
    chk_rsp(r, '{8'hFF, 1'b0, 5'h00});
    run(EPC_CMD_PROG_FAST, 15'h0004, 8'hFF);
    chk_rsp(r, '{8'hFF, 1'b0, 5'h00});
    need = 5'h03;
    run(EPC_CMD_PROG_SHORT, 15'h0005, 8'hA5);
    chk_rsp(r, '{8'hA5, 1'b0, 5'h03});
    need = 5'h0B;
    run(EPC_CMD_PROG_SHORT, 15'h4000, 8'h00);
    chk_rsp(r, '{8'hFF, 1'b1, 5'h0A});
    run(EPC_CMD_READ, 15'h0005, 8'h00);
    chk_val({8'h00, r.data}, 16'h00A5);
  endtask
  task automatic t_fast();
    need = 5'h02;
    max_low = 16'h0000;
    run(EPC_CMD_PROG_FAST, 15'h2AAA, 8'h3C);
    chk_rsp(r, '{8'h3C, 1'b0, 5'h02});
    chk_val(max_low, 16'(6 * PRIME_CYC));
    need = 5'h1A;
    run(EPC_CMD_PROG_FAST, 15'h0100, 8'h0F);
    chk_rsp(r, '{8'hFF, 1'b1, 5'h19});
  endtask
  // A one cannot be restored over a programmed zero, so the attempt must fail.
  task automatic t_bits();
    need = 5'h01;
    run(EPC_CMD_PROG_SHORT, 15'h0005, 8'h5A);
    chk_val({15'h0000, r.fail}, 16'h0001);
    run(EPC_CMD_READ, 15'h0005, 8'h00);
    chk_val({8'h00, r.data & 8'h5A}, 16'h0000);
  endtask
  task automatic t_sig();
    for (int i = 0; i < 2; i++) begin
      run(EPC_CMD_SIGNATURE, {14'h2AAA, i[0]}, 8'h00);
      chk_val({8'h00, r.data}, {8'h00, i ? PART_CODE : MAKER_CODE});
      chk_val({14'h0000, r.fail, ^r.data}, 16'h0001);
    end
  endtask
  // A reset in mid-pulse must park the pins within five cycles and leave the controller ready.
  task automatic t_reset();
    logic [15:0] park;
    need = 5'h1A;
    @(negedge ref_clk_i);
    req_i = '{EPC_CMD_PROG_FAST, 15'h0200, 8'h00};
    req_valid_i = 1'b1;
    while (req_ready_o !== 1'b1) @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    req_valid_i = 1'b0;
    while (pins_o.chip_en_n !== 1'b0) @(negedge ref_clk_i);
    rst_n_i = 1'b0;
    repeat (5) @(negedge ref_clk_i);
    park = {pins_o.chip_en_n, pins_o.out_en_n, pins_o.data_oe, pins_o.id_high_voltage_pin, pins_o.supply,
      req_ready_o, rsp_valid_o, 8'h00};
    chk_val(park, 16'hC200);
    rst_n_i = 1'b1;
    run(EPC_CMD_READ, 15'h0200, 8'h00);
    chk_val({8'h00, r.data}, 16'h00FF);
  endtask
  initial begin
    repeat (5) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    t_short();
    t_fast();
    t_bits();
    t_sig();
    t_reset();
    close_out();
  end
endmodule
